// ### ptrop_core.sv
// execute logic for pointer loads, no-operation and port output instructions
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - top two bits set mark a pair load, x in bits 7:4, y in bits 3:0.
// - a pair load writes x to the file pointer and y to the word pointer.
// - in a run of back-to-back pair loads only the first one executes.
// - the bank load writes its two-bit immediate and never skips.
// - the all-zero word only steps the program counter.
// - code 220 copies the accumulator to port zero, no carry, no skip.
// - code 221 copies the accumulator to port one, no carry, no skip.
// - the word pointer increment skips the next word when it wraps to 0.
module ptrop_core import ptrop_pkg::*; (
	input wire logic clock,
	input wire logic nrst,
	input wire logic instr_valid,
	input wire logic [9:0] instr,
	input wire logic skip_in,
	input wire logic [3:0] acc,
	output var ptrop_ptr_t ptr,
	output var ptrop_ports_t ports,
	output logic pc_step,
	output logic skip_next,
	output logic executed
);
	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	ptrop_op_t op;
	logic port_sel;
	logic last_pair;
	logic skip_pend;
	logic skip_now;

	ptrop_decode u_decode (
		.instr(instr),
		.op(op),
		.port_sel(port_sel)
	);

	// a pair load is recognised in more than one place
	function automatic logic is_pair(input ptrop_op_t o);
		return o == ptrop_op_pair;
	endfunction : is_pair

	// a skipped pair load still counts as part of the run
	// idle cycles leave last_pair alone, so a run survives gaps
	assign skip_now = skip_in | skip_pend
		| (is_pair(op) & last_pair);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	ptrop_ptr_t next_ptr;
	ptrop_ports_t next_ports;
	logic next_pc_step;
	logic next_skip_next;
	logic next_executed;
	logic next_last_pair;
	logic next_skip_pend;
	logic [3:0] y_inc;

	always_comb begin
		y_inc = ptr.y + 4'h1;
		next_ptr = ptr;
		next_ports = ports;
		next_pc_step = 1'b0;
		next_skip_next = 1'b0;
		next_executed = 1'b0;
		next_last_pair = last_pair;
		next_skip_pend = skip_pend;
		if (instr_valid) begin
			// a skipped word still steps the program counter
			next_pc_step = 1'b1;
			next_last_pair = is_pair(op);
			next_skip_pend = 1'b0;
			next_executed = ~skip_now;
			if (!skip_now) begin
				case (op)
					ptrop_op_pair: begin
						next_ptr.x = instr[ptrop_x_lsb +: 4];
						next_ptr.y = instr[ptrop_y_lsb +: 4];
					end
					ptrop_op_bank: begin
						next_ptr.z = instr[ptrop_z_lsb +: 2];
					end
					ptrop_op_inc_y: begin
						next_ptr.y = y_inc;
						// held until the next valid word, gaps keep it
						next_skip_pend = (y_inc == 4'h0);
						next_skip_next = (y_inc == 4'h0);
					end
					ptrop_op_out_k: begin
						next_ports.k = acc[0];
					end
					ptrop_op_out_p: begin
						if (port_sel) begin
							next_ports.output_port_one = acc;
						end else begin
							next_ports.output_port_zero = acc;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// registers
	// -----------------------------------------------------------------
	// reset also drops a pending wrap skip
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ptr <= '{x: ptrop_rst_x, y: ptrop_rst_y, z: ptrop_rst_z};
			ports <= '{k: 1'b0, output_port_zero: ptrop_rst_port,
				output_port_one: ptrop_rst_port};
			pc_step <= 1'b0;
			skip_next <= 1'b0;
			executed <= 1'b0;
			last_pair <= 1'b0;
			skip_pend <= 1'b0;
		end else begin
			ptr <= next_ptr;
			ports <= next_ports;
			pc_step <= next_pc_step;
			skip_next <= next_skip_next;
			executed <= next_executed;
			last_pair <= next_last_pair;
			skip_pend <= next_skip_pend;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	// each consequent except a_pair_decode starts one edge after the word is taken; a_pair_decode checks at the same edge
	a_pair_decode: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && instr[9:8] == 2'h3 |-> op == ptrop_op_pair)
		else $error("pair load not decoded");

	a_pair_load: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op == ptrop_op_pair && !skip_now
		|=> ptr.x == $past(instr[7:4]) && ptr.y == $past(instr[3:0]))
		else $error("pair load did not write pointers");

	a_pair_run_skip: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op == ptrop_op_pair ##1
		instr_valid && op == ptrop_op_pair
		|=> $stable(ptr) && !executed)
		else $error("second pair load in a run executed");

	a_bank_load: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op == ptrop_op_bank && !skip_now
		|=> ptr.z == $past(instr[1:0]) && !skip_next)
		else $error("bank load wrong");

	a_no_op_quiet: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && instr == 10'h000
		|=> pc_step && $stable(ptr) && $stable(ports) && !skip_next)
		else $error("no-operation changed state");

	a_port_k: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && instr == 10'h21f && !skip_now
		|=> ports.k == $past(acc[0]) && $stable(ports.output_port_zero)
		&& !skip_next)
		else $error("single port latch wrong");

	a_port_zero: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && instr == 10'h220 && !skip_now
		|=> ports.output_port_zero == $past(acc)
		&& $stable(ports.output_port_one) && !skip_next)
		else $error("port zero latch wrong");

	a_port_one: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && instr == 10'h221 && !skip_now
		|=> ports.output_port_one == $past(acc)
		&& $stable(ports.output_port_zero) && !skip_next)
		else $error("port one latch wrong");

	a_pc_one_step: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid |=> pc_step ##1 (pc_step == $past(instr_valid)))
		else $error("program counter step missing");

	a_wrap_skip: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op == ptrop_op_inc_y && !skip_now && ptr.y == 4'hf
		|=> ptr.y == 4'h0 && skip_next && skip_pend)
		else $error("wrap of word pointer did not skip");

	// -----------------------------------------------------------------
	// checks on skips and holds
	// -----------------------------------------------------------------
	a_wrap_next: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && skip_pend
		|=> !executed && $stable(ptr) && $stable(ports))
		else $error("word after a wrap was not skipped");

	a_inc_no_wrap: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op == ptrop_op_inc_y && !skip_now && ptr.y != 4'hf
		|=> ptr.y == $past(ptr.y) + 4'h1 && !skip_next && !skip_pend)
		else $error("increment without wrap went wrong");

	a_pend_once: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && skip_pend |=> !skip_pend)
		else $error("wrap skip applied twice");

	a_skip_in_quiet: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && skip_in
		|=> pc_step && !executed && $stable(ptr) && $stable(ports))
		else $error("skipped word changed state");

	a_idle_quiet: assert property (@(posedge clock)
		disable iff (!nrst)
		!instr_valid |=> !pc_step && !executed && !skip_next)
		else $error("pulse without an instruction");

	a_run_restart: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op != ptrop_op_pair ##1
		instr_valid && op == ptrop_op_pair && !skip_in && !skip_pend
		|=> executed)
		else $error("pair load after another word was skipped");

	a_ports_hold: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && op != ptrop_op_out_k && op != ptrop_op_out_p
		|=> $stable(ports))
		else $error("port latch changed by another word");

	a_ptr_hold: assert property (@(posedge clock)
		disable iff (!nrst)
		instr_valid && (op == ptrop_op_out_k || op == ptrop_op_out_p)
		|=> $stable(ptr) && !skip_next)
		else $error("port output touched the pointers");
endmodule : ptrop_core
`default_nettype wire

// ### ptrop_core_bench.sv
// self-checking bench for the pointer load and port output execute block
`timescale 1ns/100ps
`default_nettype none
module ptrop_core_bench import ptrop_pkg::*;;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic instr_valid = 1'b0;
	logic [9:0] instr = 10'h000;
	logic skip_in = 1'b0;
	logic [3:0] acc = 4'h0;
	ptrop_ptr_t ptr;
	ptrop_ports_t ports;
	logic pc_step;
	logic skip_next;
	logic executed;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;

	ptrop_core DUT (.clock(clock), .nrst(nrst), .instr_valid(instr_valid),
		.instr(instr), .skip_in(skip_in), .acc(acc), .ptr(ptr),
		.ports(ports), .pc_step(pc_step), .skip_next(skip_next),
		.executed(executed));

	always #2.5 clock = ~clock;

	// ----------------------------------------
	// common tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one instruction, outputs judged 1 ns after the edge that takes it
	task automatic issue(input logic [9:0] w, input logic [3:0] a,
			input logic s);
		@(posedge clock);
		instr_valid <= 1'b1;
		instr <= w;
		acc <= a;
		skip_in <= s;
		@(posedge clock);
		instr_valid <= 1'b0;
		skip_in <= 1'b0;
		#1;
	endtask : issue

	// pc_step, executed and skip_next together
	task automatic flags(input logic e, input logic sk);
		chk({7'h0, pc_step, executed, skip_next}, {7'h0, 1'b1, e, sk});
	endtask : flags

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_pair();
		issue(10'h3a5, 4'h0, 1'b0);
		chk(ptr, {4'ha, 4'h5, 2'h0});
		flags(1'b1, 1'b0);
		issue(10'h3ff, 4'h0, 1'b0);
		chk(ptr, {4'ha, 4'h5, 2'h0});
		flags(1'b0, 1'b0);
		issue(10'h000, 4'h0, 1'b0);
		chk(ptr, {4'ha, 4'h5, 2'h0});
		flags(1'b1, 1'b0);
		issue(10'h3f0, 4'h0, 1'b0);
		chk(ptr, {4'hf, 4'h0, 2'h0});
	endtask : t_pair

	task automatic t_bank();
		for (int z = 0; z < 4; z++) begin
			issue({ptrop_code_bank_hi, 2'(3 - z)}, 4'h0, 1'b0);
			chk(ptr, {4'hf, 4'h0, 2'(3 - z)});
			flags(1'b1, 1'b0);
		end
		// bank load breaks a pair-load run
		issue(10'h312, 4'h0, 1'b0);
		chk(ptr, {4'h1, 4'h2, 2'h0});
	endtask : t_bank

	task automatic t_ports();
		issue(ptrop_code_out_k, 4'he, 1'b0);
		chk({1'b0, ports}, 10'h000);
		issue(ptrop_code_out_k, 4'h1, 1'b0);
		chk({1'b0, ports}, 10'h100);
		issue(ptrop_code_out_zero, 4'h9, 1'b0);
		chk({1'b0, ports}, 10'h190);
		issue(ptrop_code_out_one, 4'h6, 1'b0);
		chk({1'b0, ports}, 10'h196);
		flags(1'b1, 1'b0);
		issue(ptrop_code_out_zero, 4'h3, 1'b1);
		chk({1'b0, ports}, 10'h196);
		flags(1'b0, 1'b0);
	endtask : t_ports

	task automatic t_wrap();
		issue(10'h3ce, 4'h0, 1'b0);
		issue(ptrop_code_inc_y, 4'h0, 1'b0);
		chk(ptr, {4'hc, 4'hf, 2'h0});
		flags(1'b1, 1'b0);
		issue(ptrop_code_inc_y, 4'h0, 1'b0);
		chk(ptr, {4'hc, 4'h0, 2'h0});
		flags(1'b1, 1'b1);
		// instruction after the wrap is skipped
		issue(ptrop_code_out_one, 4'h0, 1'b0);
		chk({1'b0, ports}, 10'h196);
		flags(1'b0, 1'b0);
	endtask : t_wrap

	// back-to-back words: a pair-load run and an unknown code
	task automatic t_burst();
		@(posedge clock);
		instr_valid <= 1'b1;
		instr <= ptrop_code_no_operation;
		acc <= 4'h0;
		skip_in <= 1'b0;
		@(posedge clock);
		instr <= 10'h312;
		#1;
		flags(1'b1, 1'b0);
		@(posedge clock);
		instr <= 10'h345;
		#1;
		chk(ptr, {4'h1, 4'h2, 2'h0});
		flags(1'b1, 1'b0);
		@(posedge clock);
		instr <= 10'h001;
		#1;
		chk(ptr, {4'h1, 4'h2, 2'h0});
		flags(1'b0, 1'b0);
		@(posedge clock);
		instr_valid <= 1'b0;
		#1;
		chk(ptr, {4'h1, 4'h2, 2'h0});
		chk({1'b0, ports}, 10'h196);
		flags(1'b1, 1'b0);
	endtask : t_burst

	// reset in mid-run drops a pending wrap skip
	task automatic t_reset();
		issue(10'h30f, 4'h0, 1'b0);
		issue(ptrop_code_inc_y, 4'h0, 1'b0);
		flags(1'b1, 1'b1);
		@(posedge clock);
		nrst <= 1'b0;
		@(posedge clock);
		#1;
		chk(ptr, 10'h000);
		chk({1'b0, ports}, 10'h000);
		@(posedge clock);
		nrst <= 1'b1;
		issue(ptrop_code_out_one, 4'h5, 1'b0);
		chk({1'b0, ports}, 10'h005);
		flags(1'b1, 1'b0);
	endtask : t_reset

	// ----------------------------------------
	// hang guard and main sequence
	// ----------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			mismatches++;
			stop_test();
		end
	end

	initial begin
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		#1;
		chk(ptr, 10'h000);
		chk({1'b0, ports}, 10'h000);
		t_pair();
		t_bank();
		t_ports();
		t_wrap();
		t_burst();
		t_reset();
		stop_test();
	end
endmodule : ptrop_core_bench
`default_nettype wire

// ### ptrop_decode.sv
// opcode classifier for the pointer load and port output group
`timescale 1ns/100ps
`default_nettype none
module ptrop_decode import ptrop_pkg::*; (
	input wire logic [9:0] instr,
	output var ptrop_op_t op,
	output logic port_sel
);
	always_comb begin
		port_sel = 1'b0;
		if (instr[9:8] == ptrop_code_pair_hi) begin
			op = ptrop_op_pair;
		end else if (instr[9:2] == ptrop_code_bank_hi) begin
			op = ptrop_op_bank;
		end else begin
			case (instr)
				ptrop_code_no_operation: op = ptrop_op_no_operation;
				ptrop_code_inc_y: op = ptrop_op_inc_y;
				ptrop_code_out_k: op = ptrop_op_out_k;
				ptrop_code_out_zero: op = ptrop_op_out_p;
				ptrop_code_out_one: begin
					op = ptrop_op_out_p;
					port_sel = 1'b1;
				end
				default: op = ptrop_op_other;
			endcase
		end
	end
endmodule : ptrop_decode
`default_nettype wire

// ### ptrop_pkg.sv
// shared constants and types for the pointer load and port output decoder
package ptrop_pkg;
	localparam int ptrop_iw = 10;
	// opcode patterns of the fixed-code instructions
	localparam logic [9:0] ptrop_code_no_operation = 10'h000;
	localparam logic [9:0] ptrop_code_inc_y = 10'h013;
	localparam logic [9:0] ptrop_code_out_k = 10'h21f;
	localparam logic [9:0] ptrop_code_out_zero = 10'h220;
	localparam logic [9:0] ptrop_code_out_one = 10'h221;
	// bank pointer load: upper eight bits fixed, two low bits immediate
	localparam logic [7:0] ptrop_code_bank_hi = 8'h12;
	// pointer pair load: two top bits set
	localparam logic [1:0] ptrop_code_pair_hi = 2'h3;
	// immediate field positions
	localparam int ptrop_x_lsb = 4;
	localparam int ptrop_y_lsb = 0;
	localparam int ptrop_z_lsb = 0;
	// reset values
	localparam logic [3:0] ptrop_rst_x = 4'h0;
	localparam logic [3:0] ptrop_rst_y = 4'h0;
	localparam logic [1:0] ptrop_rst_z = 2'h0;
	localparam logic [3:0] ptrop_rst_port = 4'h0;
	localparam logic [3:0] ptrop_y_max = 4'hf;

	typedef enum logic [6:0] {
		ptrop_op_other = 7'b0000001,
		ptrop_op_no_operation = 7'b0000010,
		ptrop_op_pair = 7'b0000100,
		ptrop_op_bank = 7'b0001000,
		ptrop_op_inc_y = 7'b0010000,
		ptrop_op_out_k = 7'b0100000,
		ptrop_op_out_p = 7'b1000000
	} ptrop_op_t;

	typedef struct packed {
		logic [3:0] x;
		logic [3:0] y;
		logic [1:0] z;
	} ptrop_ptr_t;

	typedef struct packed {
		logic k;
		logic [3:0] output_port_zero;
		logic [3:0] output_port_one;
	} ptrop_ports_t;
endpackage : ptrop_pkg
